// *** rtl/dbgcm_top.sv ***
// Debug comparators, match qualification and a compact trigger sequencer.
// Assumes an APB master on clk_sys and processor bus inputs synchronous to it.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module dbgcm_top
	import dbgcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [DBGCM_PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dbgcm_bus_s cpu_bus,
	input wire logic bdm_active,
	input wire logic bdm_access,
	input wire logic secure_mode,
	input wire logic exec_valid,
	input wire logic [DBGCM_ADDR_W-1:0] exec_addr,
	input wire logic queue_flush,
	output logic brk_req,
	output logic trace_store,
	output logic [DBGCM_NCOMP-1:0] tag_mark
);

	// ****************************************
	// State and comparator wiring
	// ****************************************

	dbgcm_state_s st_reg;
	dbgcm_state_s st_next;

	logic [DBGCM_NCOMP-1:0] force_hit;
	logic [DBGCM_NCOMP-1:0] fetch_hit;
	logic [DBGCM_NCOMP-1:0] qual_ok;
	logic [DBGCM_NCOMP-1:0] below;
	logic [DBGCM_NCOMP-1:0] above;
	logic [DBGCM_NCOMP-1:0] taghit;
	logic [DBGCM_NCOMP-1:0] ch_force;
	logic [DBGCM_NCOMP-1:0] ch_mark;
	logic [15:0] cdata;
	logic [15:0] cmask;
	logic armed;
	logic range_on;
	logic range_cond;
	logic tag_flush;

	assign cdata = {st_reg.data_high, st_reg.data_low};
	assign cmask = {st_reg.mask_high, st_reg.mask_low};
	assign armed = st_reg.seq != DBGCM_SEQ_IDLE;
	assign tag_flush = queue_flush || !armed;

	generate
		for (genvar i = 0; i < DBGCM_NCOMP; i++)
		begin : g_comp
			dbgcm_comparator #(
				.HAS_DATA(i == 0),
				.HAS_SIZE(i == 1)
			) u_comp (
				.ctrl(st_reg.comp_ctrl[i]),
				.caddr(st_reg.comp_addr[i]),
				.bus(st_reg.bus),
				.cdata(cdata),
				.cmask(cmask),
				.force_hit(force_hit[i]),
				.fetch_hit(fetch_hit[i]),
				.qual_ok(qual_ok[i]),
				.below(below[i]),
				.above(above[i])
			);
			dbgcm_tagger u_tag (
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.mark(ch_mark[i]),
				.mark_addr(st_reg.bus.addr),
				.exec_valid(exec_valid),
				.exec_addr(exec_addr),
				.flush(tag_flush),
				.taghit(taghit[i])
			);
		end
	endgenerate

	// ****************************************
	// Channel mapping and range modes
	// ****************************************

	// Range needs both A and B enabled; A's qualifiers and tag bit govern it
	assign range_on = (st_reg.range_ctl != DBGCM_RANGE_OFF)
		&& st_reg.comp_ctrl[0][DBGCM_CC_ENABLE] && st_reg.comp_ctrl[1][DBGCM_CC_ENABLE];
	assign range_cond = st_reg.bus.valid && ((st_reg.range_ctl == DBGCM_RANGE_INSIDE)
		? (above[0] && below[1])
		: (below[0] || above[1]));

	always_comb
	begin
		ch_force = force_hit;
		ch_mark = fetch_hit;
		if (range_on)
		begin
			ch_force[0] = range_cond && !st_reg.comp_ctrl[0][DBGCM_CC_TAG] && qual_ok[0];
			ch_mark[0] = range_cond && st_reg.comp_ctrl[0][DBGCM_CC_TAG]
				&& st_reg.bus.fetch;
			ch_force[1] = 1'b0;
			ch_mark[1] = 1'b0;
		end
		if (!armed)
		begin
			ch_force = '0;
			ch_mark = '0;
		end
	end

	// ****************************************
	// Next state
	// ****************************************

	always_comb
	begin
		logic [7:0] idx;
		logic [1:0] view;
		logic locked;
		logic view_ok;
		logic rd_hit;
		logic [7:0] rd_byte;
		logic wr;
		logic immediate_trigger_bit;
		logic enter_final;
		logic [DBGCM_NCOMP-1:0] ev;
		logic [7:0] cc_mask;

		idx = paddr[9:2];
		view = st_reg.ctrl_one[1:0];
		locked = st_reg.ctrl_one[DBGCM_C1_ARM];
		view_ok = view <= DBGCM_VIEW_C;
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		wr = psel && penable && st_reg.pready && pwrite;
		immediate_trigger_bit = 1'b0;
		enter_final = 1'b0;
		ev = st_reg.match | st_reg.taghit;
		cc_mask = DBGCM_CC_MASK_C;
		if (view == DBGCM_VIEW_A)
		begin
			cc_mask = DBGCM_CC_MASK_A;
		end
		else if (view == 2'h1)
		begin
			cc_mask = DBGCM_CC_MASK_B;
		end

		st_next = st_reg;

		// Bus sample stage; background debug silences every comparator
		st_next.bus = cpu_bus;
		st_next.bus.valid = cpu_bus.valid && !bdm_active && !bdm_access;
		st_next.match = ch_force;
		st_next.tag_mark = ch_mark;
		st_next.taghit = armed ? taghit : '0;

		// Read decode in the setup phase, answered in the first access cycle
		case (idx)
			DBGCM_IDX_CTRL_ONE: rd_byte = st_reg.ctrl_one;
			DBGCM_IDX_STATUS: rd_byte = {st_reg.trace_store, 1'b0, st_reg.last_chan, 2'b00,
				st_reg.seq};
			DBGCM_IDX_RANGE: rd_byte = {6'h00, st_reg.range_ctl};
			DBGCM_IDX_COMP_CTRL: rd_byte = view_ok ? st_reg.comp_ctrl[view] : 8'h00;
			DBGCM_IDX_ADDR_HIGH: rd_byte = view_ok
				? {6'h00, st_reg.comp_addr[view][17:16]} : 8'h00;
			DBGCM_IDX_ADDR_MID: rd_byte = view_ok ? st_reg.comp_addr[view][15:8] : 8'h00;
			DBGCM_IDX_ADDR_LOW: rd_byte = view_ok ? st_reg.comp_addr[view][7:0] : 8'h00;
			DBGCM_IDX_DATA_HIGH: rd_byte = (view == DBGCM_VIEW_A) ? st_reg.data_high : 8'h00;
			DBGCM_IDX_DATA_LOW: rd_byte = (view == DBGCM_VIEW_A) ? st_reg.data_low : 8'h00;
			DBGCM_IDX_DATA_HMASK: rd_byte = (view == DBGCM_VIEW_A) ? st_reg.mask_high : 8'h00;
			DBGCM_IDX_DATA_LMASK: rd_byte = (view == DBGCM_VIEW_A)
				? st_reg.mask_low : 8'h00;
			default: rd_hit = 1'b0;
		endcase
		if ((paddr[1:0] != 2'b00) || (paddr[11:10] != 2'b00))
		begin
			rd_hit = 1'b0;
		end

		st_next.pready = psel && !penable;
		st_next.prdata = 32'h0000_0000;
		st_next.pslverr = 1'b0;
		if (psel && !penable)
		begin
			st_next.prdata = rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			st_next.pslverr = !rd_hit;
		end

		// Writes take effect at the completing access edge
		if (wr && rd_hit)
		begin
			case (idx)
				DBGCM_IDX_CTRL_ONE:
				begin
					st_next.ctrl_one = pwdata[7:0] & DBGCM_C1_WMASK;
					immediate_trigger_bit = pwdata[DBGCM_C1_IMMEDIATE_TRIGGER_BIT];
				end
				DBGCM_IDX_RANGE:
				begin
					if (!locked)
					begin
						st_next.range_ctl = pwdata[1:0];
					end
				end
				DBGCM_IDX_COMP_CTRL:
				begin
					if (!locked && view_ok)
					begin
						st_next.comp_ctrl[view] = pwdata[7:0] & cc_mask;
					end
				end
				DBGCM_IDX_ADDR_HIGH:
				begin
					if (!locked && view_ok)
					begin
						st_next.comp_addr[view][17:16] = pwdata[1:0];
					end
				end
				DBGCM_IDX_ADDR_MID:
				begin
					if (!locked && view_ok)
					begin
						st_next.comp_addr[view][15:8] = pwdata[7:0];
					end
				end
				DBGCM_IDX_ADDR_LOW:
				begin
					if (!locked && view_ok)
					begin
						st_next.comp_addr[view][7:0] = pwdata[7:0];
					end
				end
				DBGCM_IDX_DATA_HIGH:
				begin
					if (!locked && (view == DBGCM_VIEW_A))
					begin
						st_next.data_high = pwdata[7:0];
					end
				end
				DBGCM_IDX_DATA_LOW:
				begin
					if (!locked && (view == DBGCM_VIEW_A))
					begin
						st_next.data_low = pwdata[7:0];
					end
				end
				DBGCM_IDX_DATA_HMASK:
				begin
					if (!locked && (view == DBGCM_VIEW_A))
					begin
						st_next.mask_high = pwdata[7:0];
					end
				end
				DBGCM_IDX_DATA_LMASK:
				begin
					if (!locked && (view == DBGCM_VIEW_A))
					begin
						st_next.mask_low = pwdata[7:0];
					end
				end
				default:
				begin
				end
			endcase
		end

		// ****************************************
		// Sequencer
		// ****************************************

		case (st_reg.seq)
			DBGCM_SEQ_IDLE:
			begin
				if (st_next.ctrl_one[DBGCM_C1_ARM])
				begin
					st_next.seq = DBGCM_SEQ_ARMED;
				end
			end
			DBGCM_SEQ_ARMED:
			begin
				// Lowest channel wins; the event is consumed, not rechecked
				if (ev != '0)
				begin
					st_next.seq = DBGCM_SEQ_FINAL;
					enter_final = 1'b1;
					if (ev[0])
					begin
						st_next.last_chan = 2'h0;
					end
					else if (ev[1])
					begin
						st_next.last_chan = 2'h1;
					end
					else
					begin
						st_next.last_chan = 2'h2;
					end
				end
			end
			DBGCM_SEQ_FINAL:
			begin
			end
			default:
			begin
				st_next.seq = DBGCM_SEQ_IDLE;
			end
		endcase

		if (immediate_trigger_bit && st_next.ctrl_one[DBGCM_C1_ARM] && (st_reg.seq != DBGCM_SEQ_FINAL))
		begin
			st_next.seq = DBGCM_SEQ_FINAL;
			st_next.last_chan = DBGCM_CHAN_IMMEDIATE_TRIGGER_BIT;
			enter_final = 1'b1;
		end
		if (!st_next.ctrl_one[DBGCM_C1_ARM])
		begin
			st_next.seq = DBGCM_SEQ_IDLE;
			enter_final = 1'b0;
		end

		st_next.brk_req = enter_final && st_reg.ctrl_one[DBGCM_C1_BRK_EN]
			|| (enter_final && immediate_trigger_bit && st_next.ctrl_one[DBGCM_C1_BRK_EN]);
		st_next.trace_store = (st_next.seq == DBGCM_SEQ_FINAL)
			&& st_next.ctrl_one[DBGCM_C1_TRACE_EN] && !secure_mode;
	end

	// ****************************************
	// Registers and outputs
	// ****************************************

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign brk_req = st_reg.brk_req;
	assign trace_store = st_reg.trace_store;
	assign tag_mark = st_reg.tag_mark;

endmodule

`default_nettype wire

// *** rtl/dbgcm_pkg.sv ***
// Constants, field layouts and carrier types of the debug comparator block.
// Assumes a 50 MHz system clock and APB register access with 32-bit data.
//
// Behaviour
// - Data low mask bit 0 ignores that data bit; bit 1 compares it.
// - Data low mask readable only at view 00; writable at view 00 when disarmed.
// - Comparator A compares data only while its tag bit is clear.
// - Secure part may still break but never stores trace data.
// - Sequencer, trace storage and breakpoints act only once armed.
// - Three comparators on the address bus; only A also compares masked data.
// - A forced match moves the sequencer without waiting for execution.
// - A tagged match marks the fetch; transition only when that opcode executes.
// - Entering the final state starts tracing and/or a breakpoint as configured.
// - Writing the immediate trigger bit forces the final state, with breakpoint if breakpoint enable is set.
// - Comparators are off in background debug mode and its accesses.
// - Exact or range matching; range fires inside or outside as selected.
// - Direction enable chooses whether direction counts; select picks read or write.
// - Tagging ignores direction, size and data; exact opcode address only.
// - Untagged match fires when the address shows on the bus, fetch included.
// - A match event is not rechecked later against its original condition.
// - Channels 0, 1, 2 come from comparators A, B, C except in range mode.
// - A and C ignore access size and match the exact address only.
// - Word data: lower-address byte meets data high; byte uses high only (the comparator ignores byte_acc and compares both bytes under the mask).
// - Inverted-data bit selects match on equal or on differing data.
// - Data high mask bit 0 ignores that data bit; bit 1 compares it.
// - Forced match reaches the sequencer two to three cycles after the bus cycle.

package dbgcm_pkg;

	localparam int DBGCM_ADDR_W = 18;
	localparam int DBGCM_DATA_W = 16;
	localparam int DBGCM_NCOMP = 3;
	localparam int DBGCM_PADDR_W = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0] DBGCM_IDX_CTRL_ONE = 8'h20;
	localparam logic [7:0] DBGCM_IDX_STATUS = 8'h21;
	localparam logic [7:0] DBGCM_IDX_RANGE = 8'h22;
	localparam logic [7:0] DBGCM_IDX_COMP_CTRL = 8'h28;
	localparam logic [7:0] DBGCM_IDX_ADDR_HIGH = 8'h29;
	localparam logic [7:0] DBGCM_IDX_ADDR_MID = 8'h2A;
	localparam logic [7:0] DBGCM_IDX_ADDR_LOW = 8'h2B;
	localparam logic [7:0] DBGCM_IDX_DATA_HIGH = 8'h2C;
	localparam logic [7:0] DBGCM_IDX_DATA_LOW = 8'h2D;
	localparam logic [7:0] DBGCM_IDX_DATA_HMASK = 8'h2E;
	localparam logic [7:0] DBGCM_IDX_DATA_LMASK = 8'h2F;

	// debug_control_one fields
	localparam int DBGCM_C1_ARM = 7;
	localparam int DBGCM_C1_IMMEDIATE_TRIGGER_BIT = 6;
	localparam int DBGCM_C1_TRACE_EN = 4;
	localparam int DBGCM_C1_BRK_EN = 3;
	localparam logic [7:0] DBGCM_C1_WMASK = 8'h9B;

	// Comparator control fields
	localparam int DBGCM_CC_ENABLE = 6;
	localparam int DBGCM_CC_TAG = 5;
	localparam int DBGCM_CC_NDB = 4;
	localparam int DBGCM_CC_RWE = 3;
	localparam int DBGCM_CC_RW = 2;
	localparam int DBGCM_CC_SZE = 1;
	localparam int DBGCM_CC_SZ = 0;
	localparam logic [7:0] DBGCM_CC_MASK_A = 8'h7C;
	localparam logic [7:0] DBGCM_CC_MASK_B = 8'h6F;
	localparam logic [7:0] DBGCM_CC_MASK_C = 8'h6C;

	localparam logic [7:0] DBGCM_RESET_BYTE = 8'h00;

	localparam logic [1:0] DBGCM_VIEW_A = 2'h0;
	localparam logic [1:0] DBGCM_VIEW_C = 2'h2;
	localparam logic [1:0] DBGCM_RANGE_OFF = 2'h0;
	localparam logic [1:0] DBGCM_RANGE_INSIDE = 2'h1;
	localparam logic [1:0] DBGCM_RANGE_OUTSIDE = 2'h2;
	localparam logic [1:0] DBGCM_CHAN_IMMEDIATE_TRIGGER_BIT = 2'h3;

	typedef enum logic [1:0] {
		DBGCM_SEQ_IDLE = 2'b00,
		DBGCM_SEQ_ARMED = 2'b01,
		DBGCM_SEQ_FINAL = 2'b11
	} dbgcm_seq_e;

	typedef struct packed {
		logic valid;
		logic read;
		logic byte_acc;
		logic fetch;
		logic [DBGCM_ADDR_W-1:0] addr;
		logic [DBGCM_DATA_W-1:0] data;
	} dbgcm_bus_s;

	typedef struct packed {
		logic valid;
		logic [DBGCM_ADDR_W-1:0] addr;
	} dbgcm_tag_s;

	typedef struct packed {
		logic [7:0] ctrl_one;
		logic [1:0] range_ctl;
		logic [DBGCM_NCOMP-1:0][7:0] comp_ctrl;
		logic [DBGCM_NCOMP-1:0][DBGCM_ADDR_W-1:0] comp_addr;
		logic [7:0] data_high;
		logic [7:0] data_low;
		logic [7:0] mask_high;
		logic [7:0] mask_low;
		dbgcm_bus_s bus;
		logic [DBGCM_NCOMP-1:0] match;
		logic [DBGCM_NCOMP-1:0] taghit;
		logic [DBGCM_NCOMP-1:0] tag_mark;
		dbgcm_seq_e seq;
		logic [1:0] last_chan;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic brk_req;
		logic trace_store;
	} dbgcm_state_s;

endpackage

// *** rtl/dbgcm_comparator.sv ***
// One address comparator with optional data and size qualification.
// Assumes the bus sample is registered and already gated for background debug.
`timescale 1ns/10ps
`default_nettype none

module dbgcm_comparator
	import dbgcm_pkg::*;
#(
	parameter bit HAS_DATA = 1'b0,
	parameter bit HAS_SIZE = 1'b0
)
(
	input wire logic [7:0] ctrl,
	input wire logic [DBGCM_ADDR_W-1:0] caddr,
	input wire dbgcm_bus_s bus,
	input wire logic [15:0] cdata,
	input wire logic [15:0] cmask,
	output logic force_hit,
	output logic fetch_hit,
	output logic qual_ok,
	output logic below,
	output logic above
);

	logic addr_eq;
	logic dir_ok;
	logic size_ok;
	logic data_ok;
	logic data_same;

	generate
		if (HAS_DATA && HAS_SIZE)
		begin : g_bad
			$error("dbgcm_comparator: data and size qualification are exclusive");
		end
	endgenerate

	assign addr_eq = bus.addr == caddr;
	assign below = bus.addr < caddr;
	assign above = bus.addr > caddr;
	assign dir_ok = !ctrl[DBGCM_CC_RWE] || (ctrl[DBGCM_CC_RW] == bus.read);
	assign size_ok = !HAS_SIZE || !ctrl[DBGCM_CC_SZE] || (ctrl[DBGCM_CC_SZ] == bus.byte_acc);
	// Byte accesses carry their byte on the high lane
	assign data_same = ((bus.data ^ cdata) & cmask) == 16'h0000;
	assign data_ok = !HAS_DATA || ctrl[DBGCM_CC_TAG] || (data_same ^ ctrl[DBGCM_CC_NDB]);
	assign qual_ok = dir_ok && size_ok && data_ok;
	assign force_hit = bus.valid && ctrl[DBGCM_CC_ENABLE] && !ctrl[DBGCM_CC_TAG] && addr_eq
		&& qual_ok;
	// Tagging looks only at the exact opcode address of a fetch
	assign fetch_hit = bus.valid && ctrl[DBGCM_CC_ENABLE] && ctrl[DBGCM_CC_TAG] && bus.fetch
		&& addr_eq;

endmodule

`default_nettype wire

// *** rtl/dbgcm_tagger.sv ***
// Opcode tag holder for one match channel.
// Assumes the core reports each executed opcode address with a valid strobe.
`timescale 1ns/10ps
`default_nettype none

module dbgcm_tagger
	import dbgcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic mark,
	input wire logic [DBGCM_ADDR_W-1:0] mark_addr,
	input wire logic exec_valid,
	input wire logic [DBGCM_ADDR_W-1:0] exec_addr,
	input wire logic flush,
	output logic taghit
);

	dbgcm_tag_s tag_reg;
	dbgcm_tag_s tag_next;

	assign taghit = tag_reg.valid && exec_valid && (exec_addr == tag_reg.addr);

	always_comb
	begin
		tag_next = tag_reg;
		if (flush || taghit)
		begin
			tag_next.valid = 1'b0;
		end
		if (mark)
		begin
			tag_next.valid = 1'b1;
			tag_next.addr = mark_addr;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tag_reg <= '0;
		end
		else
		begin
			tag_reg <= tag_next;
		end
	end

endmodule

`default_nettype wire

// *** test/dbgcm_assertions.sv ***
// Port-level checker for dbgcm_top: register access and match outputs.
// Assumes the single clk_sys domain with rst_b as asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module dbgcm_assertions
	import dbgcm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire dbgcm_bus_s cpu_bus,
	input wire logic bdm_active,
	input wire logic bdm_access,
	input wire logic secure_mode,
	input wire logic brk_req,
	input wire logic trace_store,
	input wire logic [DBGCM_NCOMP-1:0] tag_mark
);
	// ****************
	// Properties
	// ****************
	logic fetch_seen;
	assign fetch_seen = cpu_bus.valid & cpu_bus.fetch;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	a_setup_answer: assert property (s_setup |=> s_answer)
		else $error("register access not answered in one cycle");
	a_error_ready: assert property (pslverr |-> pready)
		else $error("error response outside an answer");
	a_read_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_quiet_data: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data driven outside an answer");
	a_brk_single: assert property (brk_req |=> !brk_req)
		else $error("breakpoint request longer than one cycle");
	a_secure_trace: assert property (secure_mode && $past(secure_mode) |-> !trace_store)
		else $error("trace storage while secure");
	a_bdm_blind: assert property ((bdm_active || bdm_access) |-> ##2 tag_mark == 3'h0)
		else $error("tag raised from a background debug cycle");
	a_tag_fetch: assert property (tag_mark != 3'h0 |-> $past(fetch_seen, 2))
		else $error("tag raised without an opcode fetch");
endmodule
bind dbgcm_top dbgcm_assertions dbgcm_assertions_inst
(
	.clk_sys(clk_sys),
	.rst_b(rst_b),
	.psel(psel),
	.penable(penable),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.cpu_bus(cpu_bus),
	.bdm_active(bdm_active),
	.bdm_access(bdm_access),
	.secure_mode(secure_mode),
	.brk_req(brk_req),
	.trace_store(trace_store),
	.tag_mark(tag_mark)
);
`default_nettype wire

// *** test/dbgcm_cpu_model.sv ***
// Processor core model: bus cycles, executed opcodes and queue flushes.
// Assumes callers enter its tasks right after a rising clk_sys edge.
`timescale 1ns/10ps
`default_nettype none
module dbgcm_cpu_model
	import dbgcm_pkg::*;
(
	input wire logic clk_sys,
	output dbgcm_bus_s cpu_bus,
	output logic exec_valid,
	output logic [DBGCM_ADDR_W-1:0] exec_addr,
	output logic queue_flush
);
	// ****************
	// Bus activity
	// ****************
	initial
	begin
		cpu_bus = '0;
		exec_valid = 1'b0;
		exec_addr = '0;
		queue_flush = 1'b0;
	end
	// Idle bus shows inverted values, never the stale ones
	task automatic bus_cycle(input dbgcm_bus_s b);
		dbgcm_bus_s idle;
		idle = ~b;
		idle.valid = 1'b0;
		cpu_bus <= b;
		@(posedge clk_sys);
		cpu_bus <= idle;
	endtask
	task automatic execute(input logic [DBGCM_ADDR_W-1:0] a);
		exec_valid <= 1'b1;
		exec_addr <= a;
		@(posedge clk_sys);
		exec_valid <= 1'b0;
		exec_addr <= ~a;
	endtask
	task automatic flush();
		queue_flush <= 1'b1;
		@(posedge clk_sys);
		queue_flush <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** test/test_debug_comparator_match.sv ***
// Testbench of dbgcm_top: APB register tasks and match trials.
// Assumes dbgcm_cpu_model drives the processor side.
`timescale 1ns/10ps
`default_nettype none
module test_debug_comparator_match;
	import dbgcm_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dbgcm_bus_s cpu_bus;
	logic bdm_active = 1'b0;
	logic bdm_access = 1'b0;
	logic secure_mode = 1'b0;
	logic exec_valid;
	logic [17:0] exec_addr;
	logic queue_flush;
	logic brk_req;
	logic trace_store;
	logic [2:0] tag_mark;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int brk_cnt = 0;
	int tag_cnt = 0;
	localparam logic [17:0] XA = 18'h12346;
	localparam logic [17:0] XB = 18'h1234E;
	localparam logic [17:0] YC = 18'h00AB0;
	dbgcm_top dbgcm_top_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_bus(cpu_bus),
		.bdm_active(bdm_active), .bdm_access(bdm_access), .secure_mode(secure_mode),
		.exec_valid(exec_valid), .exec_addr(exec_addr), .queue_flush(queue_flush),
		.brk_req(brk_req), .trace_store(trace_store), .tag_mark(tag_mark));
	dbgcm_cpu_model dbgcm_cpu_model_inst (.clk_sys(clk_sys), .cpu_bus(cpu_bus),
		.exec_valid(exec_valid), .exec_addr(exec_addr), .queue_flush(queue_flush));
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		brk_cnt <= brk_cnt + int'(brk_req);
		tag_cnt <= tag_cnt + int'(tag_mark != 3'h0);
		if (cycles == 6000)
		begin
			failures++;
			end_of_test();
		end
	end
	// ****************
	// Tasks
	// ****************
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		if (n >= 20)
			failures++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, idx, d, q, e);
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, idx, 8'h00, q, e);
		check(q, {24'h000000, x});
		check(32'(e), 32'(xe));
	endtask
	task automatic cfg(input logic [7:0] view, input logic [7:0] c, input logic [17:0] a);
		wr(DBGCM_IDX_CTRL_ONE, view);
		wr(DBGCM_IDX_COMP_CTRL, c);
		wr(DBGCM_IDX_ADDR_HIGH, {6'h00, a[17:16]});
		wr(DBGCM_IDX_ADDR_MID, a[15:8]);
		wr(DBGCM_IDX_ADDR_LOW, a[7:0]);
	endtask
	function automatic dbgcm_bus_s mk(input logic r, input logic f, input logic [17:0] a,
		input logic [15:0] d);
		return '{valid: 1'b1, read: r, byte_acc: 1'b0, fetch: f, addr: a, data: d};
	endfunction
	// Mode 1 executes the opcode later, mode 2 flushes the queue first
	task automatic trial(input logic [7:0] arm, input dbgcm_bus_s b, input int mode,
		input int xb, input logic xt);
		int c0;
		int t0;
		wr(DBGCM_IDX_CTRL_ONE, arm);
		c0 = brk_cnt;
		t0 = tag_cnt;
		dbgcm_cpu_model_inst.bus_cycle(b);
		repeat (5) @(posedge clk_sys);
		if (mode != 0)
		begin
			check(brk_cnt - c0, 0);
			if (mode == 2)
				dbgcm_cpu_model_inst.flush();
			dbgcm_cpu_model_inst.execute(b.addr);
			repeat (5) @(posedge clk_sys);
		end
		check(brk_cnt - c0, xb);
		check(tag_cnt - t0, 32'(mode != 0));
		check(32'(trace_store), 32'(xt));
		wr(DBGCM_IDX_CTRL_ONE, 8'h00);
	endtask
	// ****************
	// Sequence
	// ****************
	initial
	begin
		int c0;
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(DBGCM_IDX_DATA_LMASK, 8'h00, 1'b0);
		rd(DBGCM_IDX_DATA_HMASK, 8'h00, 1'b0);
		cfg(8'h00, 8'h40, XA);
		wr(DBGCM_IDX_DATA_HIGH, 8'h12);
		wr(DBGCM_IDX_DATA_LOW, 8'h34);
		wr(DBGCM_IDX_DATA_HMASK, 8'hFF);
		wr(DBGCM_IDX_DATA_LMASK, 8'h0F);
		rd(DBGCM_IDX_DATA_LMASK, 8'h0F, 1'b0);
		wr(DBGCM_IDX_CTRL_ONE, 8'h01);
		rd(DBGCM_IDX_DATA_LMASK, 8'h00, 1'b0);
		wr(DBGCM_IDX_DATA_LMASK, 8'h55);
		wr(DBGCM_IDX_CTRL_ONE, 8'h80);
		wr(DBGCM_IDX_DATA_LMASK, 8'h55);
		rd(DBGCM_IDX_DATA_LMASK, 8'h0F, 1'b0);
		wr(DBGCM_IDX_CTRL_ONE, 8'h00);
		rd(8'h30, 8'h00, 1'b1);
		trial(8'h88, mk(1'b0, 1'b0, XA, 16'h12F4), 0, 1, 1'b0);
		trial(8'h88, mk(1'b0, 1'b0, XA, 16'h1235), 0, 0, 1'b0);
		trial(8'h88, mk(1'b0, 1'b0, XA, 16'h13F4), 0, 0, 1'b0);
		trial(8'h98, mk(1'b0, 1'b0, XA, 16'h12F4), 0, 1, 1'b1);
		trial(8'h08, mk(1'b0, 1'b0, XA, 16'h12F4), 0, 0, 1'b0);
		trial(8'h88, mk(1'b0, 1'b0, XA - 18'h00001, 16'h12F4), 0, 0, 1'b0);
		secure_mode <= 1'b1;
		trial(8'h98, mk(1'b0, 1'b0, XA, 16'h12F4), 0, 1, 1'b0);
		secure_mode <= 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			bdm_active <= (i == 0);
			bdm_access <= (i == 1);
			trial(8'h88, mk(1'b0, 1'b1, XA, 16'h12F4), 0, 0, 1'b0);
		end
		bdm_access <= 1'b0;
		cfg(8'h00, 8'h50, XA);
		trial(8'h88, mk(1'b0, 1'b0, XA, 16'h1235), 0, 1, 1'b0);
		trial(8'h88, mk(1'b0, 1'b0, XA, 16'h12F4), 0, 0, 1'b0);
		cfg(8'h00, 8'h4C, XA);
		trial(8'h88, mk(1'b0, 1'b0, XA, 16'h12F4), 0, 0, 1'b0);
		trial(8'h88, mk(1'b1, 1'b0, XA, 16'h12F4), 0, 1, 1'b0);
		cfg(8'h00, 8'h60, XA);
		trial(8'h88, mk(1'b0, 1'b1, XA, 16'h0000), 1, 1, 1'b0);
		trial(8'h88, mk(1'b0, 1'b1, XA, 16'h0000), 2, 0, 1'b0);
		cfg(8'h02, 8'h40, YC);
		trial(8'h88, mk(1'b0, 1'b0, YC, 16'h0000), 0, 1, 1'b0);
		rd(DBGCM_IDX_STATUS, 8'h20, 1'b0);
		cfg(8'h00, 8'h40, XA);
		cfg(8'h01, 8'h40, XB);
		wr(DBGCM_IDX_RANGE, 8'h01);
		trial(8'h88, mk(1'b0, 1'b0, XA + 18'h00004, 16'h12F4), 0, 1, 1'b0);
		trial(8'h88, mk(1'b0, 1'b0, XB + 18'h00002, 16'h12F4), 0, 0, 1'b0);
		wr(DBGCM_IDX_RANGE, 8'h02);
		trial(8'h88, mk(1'b0, 1'b0, XB + 18'h00002, 16'h12F4), 0, 1, 1'b0);
		c0 = brk_cnt;
		wr(DBGCM_IDX_CTRL_ONE, 8'hC8);
		repeat (4) @(posedge clk_sys);
		check(brk_cnt - c0, 1);
		rd(DBGCM_IDX_STATUS, 8'h33, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
